// [design/bls_defines.vh]
// Register map, field positions, lane and speed codes and timing counts of the link setup block
// Function
// - In SGMII mode the port runs at 1 Gb/s, 100 Mb/s or 10 Mb/s, following the speed the partner signals.
// - Each SGMII direction is one self-clocked 1.25 GBaud lane carrying 8B/10B symbols.
// - On a new control word from the PHY the port acknowledges it by setting bit 14 of its own config word.
// - Backplane negotiation pages travel as differential Manchester signalling, not fast link pulses.
// - Backplane negotiation sends and takes extended base pages and next pages and parallel-detects KX partners.
// - After backplane negotiation the MAC runs at 1 Gb/s or 10 Gb/s; the protocol only configures PCS, FEC and front end.
// - Backplane negotiation resolves between a KR and a KX partner and fixes speed and link characteristics.
// - For a partner that does not negotiate the port enables KX and declares KX once its PCS syncs.
// - Parallel detection runs whenever backplane negotiation runs, with no enable of its own.
// - With low-power link-up set outside D0 the PHY negotiates low speed only if manageability, APM wake or PME needs link, else it is off.
// - Low-power negotiation first advertises only the lowest allowed speed and adds speeds after a failed try.
`ifndef BLS_DEFINES_VH
`define BLS_DEFINES_VH
`define BLS_A_CTRL 4'h0
`define BLS_A_ABIL 4'h1
`define BLS_A_STAT 4'h2
`define BLS_A_IRQ_STAT 4'h3
`define BLS_A_IRQ_MASK 4'h4
`define BLS_A_RXCFG 4'h5
`define BLS_A_TXCFG 4'h6
`define BLS_CTRL_RESTART 0
`define BLS_CTRL_AN_EN 1
`define BLS_CTRL_SGMII_EN 2
`define BLS_CTRL_CLAUSE37_EN 3
`define BLS_CTRL_LOW_POWER_LINKUP 4
`define BLS_CTRL_NON_D0 5
`define BLS_CTRL_NEED 6
`define BLS_CTRL_LANE_LO 8
`define BLS_ABIL_KX 0
`define BLS_ABIL_KR 1
`define BLS_ABIL_FEC 2
`define BLS_LANE_SFI 3'h7
`define BLS_LANE_SGMII 3'h4
`define BLS_LANE_2G5 3'h5
`define BLS_SPD_10M 3'h0
`define BLS_SPD_100M 3'h1
`define BLS_SPD_1G 3'h2
`define BLS_SPD_2G5 3'h3
`define BLS_SPD_10G 3'h4
`define BLS_ACK_BIT 14
`define BLS_IRQ_LINK_UP 0
`define BLS_IRQ_LINK_DOWN 1
`define BLS_IRQ_SGMII_CW 2
`define BLS_IRQ_AN_FAIL 3
`define BLS_AN_TRY_NS 10000000
`define BLS_CLK_NS 4
`endif

// [design/bls_link_setup.v]
// Link setup: SGMII speed ack, backplane negotiation, low-power link-up
`timescale 1ns/1ps
`default_nettype none
`include "bls_defines.vh"
module bls_link_setup #(
	parameter TRY_CYCLES = `BLS_AN_TRY_NS / `BLS_CLK_NS,
	parameter SYNC_STABLE = 16
)
(
	input wire mclk,
	input wire rst_b,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire [15:0] sgmii_rx_cfg,
	input wire sgmii_rx_cfg_valid,
	output reg [15:0] sgmii_tx_cfg,
	input wire an_page_done,
	input wire an_lp_kr,
	input wire an_lp_kx,
	input wire an_lp_fec,
	input wire pcs_sync,
	output reg an_run,
	output reg [2:0] an_adv,
	output reg kx_mode,
	output reg kr_mode,
	output reg fec_en,
	output reg phy_disable,
	output reg [2:0] mac_speed,
	output reg link_up,
	output reg irq
);
	localparam ST_IDLE = 3'h0;
	localparam ST_AN = 3'h1;
	localparam ST_UP = 3'h2;
	localparam ST_SGMII = 3'h3;
	localparam ST_FORCED = 3'h4;
	localparam ST_OFF = 3'h5;

	reg [31:0] ctrl_r;
	reg [2:0] abil_r;
	reg [3:0] ist_r;
	reg [3:0] imask_r;
	reg [2:0] st_r;
	reg [2:0] st_nxt;
	reg [31:0] try_r;
	reg lp_wide_r;
	reg [15:0] rxcfg_r;
	reg [3:0] ev;
	reg resp_r;
	wire kx_found;
	wire [2:0] lane = ctrl_r[`BLS_CTRL_LANE_LO+2:`BLS_CTRL_LANE_LO];
	wire restart = avs_write && !avs_waitrequest &&
		avs_address == `BLS_A_CTRL && avs_writedata[`BLS_CTRL_RESTART];
	wire low_pwr_act = ctrl_r[`BLS_CTRL_LOW_POWER_LINKUP] &&
		ctrl_r[`BLS_CTRL_NON_D0];
	wire need_link = ctrl_r[`BLS_CTRL_NEED];

	function [2:0] sgmii_speed;
		input [15:0] cw;
		begin
			case (cw[11:10])
				2'b00: sgmii_speed = `BLS_SPD_10M;
				2'b01: sgmii_speed = `BLS_SPD_100M;
				default: sgmii_speed = `BLS_SPD_1G;
			endcase
		end
	endfunction

	// Parallel detect follows negotiation
	bls_sync_detect #(
		.STABLE(SYNC_STABLE)
	)
	u_bls_sync_detect (
		.mclk(mclk),
		.rst_b(rst_b),
		.enable(an_run),
		.pcs_sync(pcs_sync),
		.kx_found(kx_found)
	);

	// Avalon slave, one wait cycle per access
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			resp_r <= 1'b0;
		end
		else
		begin
			resp_r <= (avs_read || avs_write) && avs_waitrequest && !resp_r;
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest
				&& !resp_r);
			if (avs_read && avs_waitrequest && !resp_r)
			begin
				case (avs_address)
					`BLS_A_CTRL: avs_readdata <= {ctrl_r[31:1], 1'b0};
					`BLS_A_ABIL: avs_readdata <= {29'h0, abil_r};
					`BLS_A_STAT: avs_readdata <= {24'h0, kr_mode, kx_mode,
						link_up, st_r, 2'b00} | {29'h0, mac_speed} << 8;
					`BLS_A_IRQ_STAT: avs_readdata <= {28'h0, ist_r};
					`BLS_A_IRQ_MASK: avs_readdata <= {28'h0, imask_r};
					`BLS_A_RXCFG: avs_readdata <= {16'h0, rxcfg_r};
					`BLS_A_TXCFG: avs_readdata <= {16'h0, sgmii_tx_cfg};
					default: avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Register writes and sticky interrupt status
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_r <= 32'h00000000;
			abil_r <= 3'h0;
			ist_r <= 4'h0;
			imask_r <= 4'h0;
			irq <= 1'b0;
		end
		else
		begin
			if (avs_write && !avs_waitrequest)
			begin
				case (avs_address)
					`BLS_A_CTRL: ctrl_r <= avs_writedata & 32'h000007FE;
					`BLS_A_ABIL: abil_r <= avs_writedata[2:0];
					`BLS_A_IRQ_MASK: imask_r <= avs_writedata[3:0];
					default: ;
				endcase
			end
			if (avs_write && !avs_waitrequest && avs_address == `BLS_A_IRQ_STAT)
				ist_r <= (ist_r & ~avs_writedata[3:0]) | ev;
			else
				ist_r <= ist_r | ev;
			irq <= |(ist_r & imask_r);
		end
	end

	// Link state machine
	always @*
	begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE:
			begin
				if (restart || lane != 3'h0 || ctrl_r[`BLS_CTRL_SGMII_EN]
					|| ctrl_r[`BLS_CTRL_AN_EN])
				begin
					if (low_pwr_act && !need_link)
						st_nxt = ST_OFF;
					else if (ctrl_r[`BLS_CTRL_SGMII_EN])
						st_nxt = ST_SGMII;
					else if (ctrl_r[`BLS_CTRL_AN_EN])
						st_nxt = ST_AN;
					else if (lane != 3'h0)
						st_nxt = ST_FORCED;
				end
			end
			ST_AN:
			begin
				if ((an_page_done && (an_lp_kr || an_lp_kx)) || kx_found)
					st_nxt = ST_UP;
			end
			ST_UP:
			begin
				if (!pcs_sync)
					st_nxt = ST_AN;
			end
			ST_OFF:
			begin
				if (!low_pwr_act || need_link)
					st_nxt = ST_IDLE;
			end
			ST_SGMII, ST_FORCED: st_nxt = st_r;
			default: st_nxt = ST_IDLE;
		endcase
		// Low-power gate outside D0, idle included
		if (restart)
			st_nxt = ST_IDLE;
		else if (low_pwr_act && !need_link)
			st_nxt = ST_OFF;
	end

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_r <= ST_IDLE;
			try_r <= 32'h00000000;
			lp_wide_r <= 1'b0;
			rxcfg_r <= 16'h0000;
			sgmii_tx_cfg <= 16'h0000;
			an_run <= 1'b0;
			an_adv <= 3'h0;
			kx_mode <= 1'b0;
			kr_mode <= 1'b0;
			fec_en <= 1'b0;
			phy_disable <= 1'b0;
			mac_speed <= `BLS_SPD_1G;
			link_up <= 1'b0;
			ev <= 4'h0;
		end
		else
		begin
			st_r <= st_nxt;
			ev <= 4'h0;
			an_run <= (st_nxt == ST_AN);
			phy_disable <= (st_nxt == ST_OFF);
			if (restart)
				lp_wide_r <= 1'b0;
			// Retry timer widens the low-power advertisement
			if (st_nxt == ST_AN && st_r == ST_AN)
			begin
				if (try_r >= TRY_CYCLES - 1)
				begin
					try_r <= 32'h00000000;
					lp_wide_r <= 1'b1;
					ev[`BLS_IRQ_AN_FAIL] <= 1'b1;
				end
				else
					try_r <= try_r + 32'h00000001;
			end
			else
				try_r <= 32'h00000000;
			if (low_pwr_act && !lp_wide_r)
				an_adv <= abil_r[`BLS_ABIL_KX] ? {1'b0, 2'b01} :
					abil_r;
			else
				an_adv <= abil_r;
			if (st_nxt == ST_AN && st_r != ST_AN)
			begin
				kx_mode <= 1'b1;
				kr_mode <= 1'b0;
			end
			// Negotiation or parallel detect result
			if (st_r == ST_AN && st_nxt == ST_UP)
			begin
				link_up <= 1'b1;
				ev[`BLS_IRQ_LINK_UP] <= 1'b1;
				if (an_page_done && an_lp_kr && an_adv[`BLS_ABIL_KR])
				begin
					kr_mode <= 1'b1;
					kx_mode <= 1'b0;
					fec_en <= an_lp_fec && an_adv[`BLS_ABIL_FEC];
					mac_speed <= `BLS_SPD_10G;
				end
				else
				begin
					kx_mode <= 1'b1;
					kr_mode <= 1'b0;
					fec_en <= 1'b0;
					mac_speed <= `BLS_SPD_1G;
				end
			end
			// Forced lane settings
			if (st_r == ST_IDLE && st_nxt == ST_FORCED)
			begin
				link_up <= 1'b1;
				ev[`BLS_IRQ_LINK_UP] <= 1'b1;
				kr_mode <= (lane == `BLS_LANE_SFI);
				kx_mode <= (lane != `BLS_LANE_SFI);
				mac_speed <= (lane == `BLS_LANE_SFI) ? `BLS_SPD_10G :
					(lane == `BLS_LANE_2G5) ? `BLS_SPD_2G5 : `BLS_SPD_1G;
			end
			if (st_nxt == ST_SGMII && st_r != ST_SGMII)
				kx_mode <= 1'b1;
			// SGMII control word capture and acknowledge
			if (st_r == ST_SGMII && sgmii_rx_cfg_valid &&
				sgmii_rx_cfg != rxcfg_r)
			begin
				rxcfg_r <= sgmii_rx_cfg;
				sgmii_tx_cfg <= 16'h4001;
				ev[`BLS_IRQ_SGMII_CW] <= 1'b1;
				link_up <= sgmii_rx_cfg[15];
				mac_speed <= sgmii_speed(sgmii_rx_cfg);
			end
			// Leaving a link state clears it
			if ((st_r == ST_UP && st_nxt != ST_UP) ||
				(st_nxt == ST_IDLE && st_r != ST_IDLE) ||
				(st_nxt == ST_OFF && st_r != ST_OFF))
			begin
				if (link_up)
					ev[`BLS_IRQ_LINK_DOWN] <= 1'b1;
				link_up <= 1'b0;
				if (st_nxt != ST_AN)
				begin
					kx_mode <= 1'b0;
					kr_mode <= 1'b0;
				end
				fec_en <= 1'b0;
				sgmii_tx_cfg <= 16'h0000;
				rxcfg_r <= 16'h0000;
			end
		end
	end
endmodule
`default_nettype wire

// [design/bls_sync_detect.v]
// Parallel detection timer: reports KX found once PCS sync has held, while enabled, for a stable window
`timescale 1ns/1ps
`default_nettype none
module bls_sync_detect #(
	parameter STABLE = 16
)
(
	input wire mclk,
	input wire rst_b,
	input wire enable,
	input wire pcs_sync,
	output reg kx_found
);
	reg [15:0] cnt_r;
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_r <= 16'h0000;
			kx_found <= 1'b0;
		end
		else if (!enable || !pcs_sync)
		begin
			cnt_r <= 16'h0000;
			kx_found <= 1'b0;
		end
		else if (cnt_r == STABLE[15:0])
			kx_found <= 1'b1;
		else
			cnt_r <= cnt_r + 16'h0001;
	end
endmodule
`default_nettype wire

// [tb/bls_link_setup_sva.sv]
// Port assertions of the link setup block
`timescale 1ns/1ps
`default_nettype none
module bls_link_setup_sva (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [15:0] sgmii_tx_cfg,
	input wire logic pcs_sync,
	input wire logic an_run,
	input wire logic kx_mode,
	input wire logic kr_mode,
	input wire logic fec_en,
	input wire logic phy_disable,
	input wire logic [2:0] mac_speed,
	input wire logic link_up
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_lost;
		kx_mode && link_up && !pcs_sync && sgmii_tx_cfg == 16'h0000
		&& mac_speed == 3'h2;
	endsequence
	AST_ANSWER: assert property (s_req |=> !avs_waitrequest)
		else $error("Request not answered");
	AST_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("Answer too long");
	AST_ACKWORD: assert property (
		sgmii_tx_cfg != 16'h0 |-> sgmii_tx_cfg == 16'h4001)
		else $error("Bad ack word");
	AST_KRSPD: assert property (kr_mode && link_up |-> mac_speed == 3'h4)
		else $error("KR speed wrong");
	AST_KXSPD: assert property (
		kx_mode && link_up && sgmii_tx_cfg == 16'h0000
		|-> (mac_speed == 3'h2 || mac_speed == 3'h3))
		else $error("KX speed wrong");
	AST_FEC: assert property (fec_en |-> kr_mode)
		else $error("FEC outside KR");
	AST_OFF: assert property (phy_disable |-> !link_up && !an_run)
		else $error("Disabled PHY active");
	AST_LOST: assert property (s_lost |-> ##[1:3] !link_up)
		else $error("Link kept after sync loss");
	AST_PDET: assert property (
		(an_run && pcs_sync) [*5] |-> ##[0:8] (link_up && kx_mode))
		else $error("Parallel detect missed");
endmodule
bind bls_link_setup bls_link_setup_sva u_bls_link_setup_sva (.*);
`default_nettype wire

// [tb/bls_phy_model.sv]
// Link partner model: SGMII PHY, KR negotiator or legacy KX
`timescale 1ns/1ps
`default_nettype none
module bls_phy_model (
	input wire logic mclk,
	input wire logic [1:0] mode,
	input wire logic [15:0] word,
	input wire logic an_run,
	output logic [15:0] cfg = 16'hFFFF,
	output logic cfg_v = 1'b0,
	output logic page = 1'b0,
	output logic lp_kr = 1'b0,
	output logic lp_fec = 1'b0,
	output logic lp_kx = 1'b0,
	output logic sync = 1'b0
);
	always @(posedge mclk)
	begin
		cfg_v <= mode == 2'h3;
		cfg <= mode == 2'h3 ? word : ~cfg;
		page <= mode == 2'h1 && an_run && !page;
		lp_kr <= mode == 2'h1;
		lp_fec <= mode == 2'h1;
		lp_kx <= mode == 2'h1;
		sync <= mode == 2'h2 || (mode == 2'h1 && (page || sync));
	end
endmodule
`default_nettype wire

// [tb/tb_bls_link_setup.sv]
// Testbench of the link setup block
`timescale 1ns/1ps
`default_nettype none
module tb_bls_link_setup;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] rx_cfg, tx_cfg;
	logic [15:0] word = 16'h0;
	logic rx_v, pd, lkr, lfec, sync, an_run, kx_mode, kr_mode, fec_en;
	logic phy_dis, link_up, irq, lkx;
	logic [2:0] an_adv, spd;
	logic [1:0] mode = 2'h0;
	int num_errors = 0;
	int n_checks = 0;
	always #2 mclk = ~mclk;
	bls_link_setup #(.TRY_CYCLES(50), .SYNC_STABLE(4)) u_bls_link_setup (
		.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sgmii_rx_cfg(rx_cfg),
		.sgmii_rx_cfg_valid(rx_v), .sgmii_tx_cfg(tx_cfg),
		.an_page_done(pd), .an_lp_kr(lkr), .an_lp_kx(lkx),
		.an_lp_fec(lfec), .pcs_sync(sync), .an_run(an_run), .an_adv(an_adv),
		.kx_mode(kx_mode), .kr_mode(kr_mode), .fec_en(fec_en),
		.phy_disable(phy_dis), .mac_speed(spd), .link_up(link_up), .irq(irq));
	bls_phy_model u_bls_phy_model (.mclk(mclk), .mode(mode), .word(word),
		.an_run(an_run), .cfg(rx_cfg), .cfg_v(rx_v), .page(pd), .lp_kr(lkr),
		.lp_fec(lfec), .lp_kx(lkx), .sync(sync));
	function automatic logic [31:0] st();
		return {25'h0, link_up, kx_mode, kr_mode, fec_en, spd};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
			@(posedge mclk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	task automatic cfg(input logic [31:0] v);
		wr(4'h0, v);
		wr(4'h0, v | 32'h1);
		rdc(4'h0, v);
	endtask
	task automatic wait_up(input logic [2:0] s);
		repeat (300)
			if (link_up !== 1'b1 || spd !== s)
				@(posedge mclk);
	endtask
	task automatic t_regs();
		chk({irq, phy_dis, an_run, tx_cfg}, 32'h0);
		rdc(4'h2, 32'h200);
		rdc(4'hF, 32'h0);
		wr(4'h4, 32'hA);
		rdc(4'h4, 32'hA);
		$display("regs done");
	endtask
	task automatic t_kr();
		wr(4'h1, 32'h7);
		mode <= 2'h1;
		cfg(32'h2);
		wait_up(3'h4);
		chk(st(), 32'h5C);
		wr(4'h1, 32'h1);
		cfg(32'h2);
		wait_up(3'h2);
		chk(st(), 32'h62);
		$display("kr done");
	endtask
	task automatic t_kx();
		wr(4'h1, 32'h1);
		mode <= 2'h2;
		cfg(32'h2);
		wait_up(3'h2);
		chk(st(), 32'h62);
		wr(4'h3, 32'hF);
		wr(4'h4, 32'h2);
		mode <= 2'h0;
		repeat (20)
			if (irq !== 1'b1)
				@(posedge mclk);
		chk({link_up, irq}, 32'h1);
		rdc(4'h3, 32'h2);
		wr(4'h3, 32'h2);
		repeat (3) @(posedge mclk);
		chk(irq, 32'h0);
		$display("kx done");
	endtask
	task automatic t_sgmii();
		logic [2:0] s;
		mode <= 2'h3;
		cfg(32'h40C);
		for (int i = 0; i < 3; i++)
		begin
			s = 3'(i);
			word <= {1'b1, 3'h0, s[1:0], 10'h1};
			wait_up(s);
			chk(st(), 32'h60 | s);
			rdc(4'h5, {16'h0, 1'b1, 3'h0, s[1:0], 10'h1});
			repeat (50)
				if (tx_cfg !== 16'h4001)
					@(posedge mclk);
			chk(tx_cfg, 32'h4001);
		end
		$display("sgmii done");
	endtask
	task automatic t_forced();
		cfg(32'h700);
		wait_up(3'h4);
		chk(st(), 32'h54);
		cfg(32'h500);
		wait_up(3'h3);
		chk(st(), 32'h63);
		$display("forced done");
	endtask
	task automatic t_low_power();
		wr(4'h1, 32'h3);
		mode <= 2'h0;
		cfg(32'h30);
		repeat (20)
			if (phy_dis !== 1'b1)
				@(posedge mclk);
		chk({phy_dis, link_up, an_run}, 32'h4);
		cfg(32'h72);
		repeat (20)
			if (an_run !== 1'b1)
				@(posedge mclk);
		chk({an_run, an_adv}, 32'h9);
		repeat (300)
			if (an_adv !== 3'h3)
				@(posedge mclk);
		chk({an_run, an_adv}, 32'hB);
		$display("low power done");
	endtask
	task automatic finish_test();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		t_regs();
		t_kr();
		t_kx();
		t_sgmii();
		t_low_power();
		t_forced();
		finish_test();
	end
	initial
	begin
		#40000;
		num_errors++;
		finish_test();
	end
endmodule
`default_nettype wire
